// ### verilog/isai_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Either line low too long (over 33 ms) resets the interface and releases data.
// - After that timeout, ignore the bus until the next Start.
// - The byte sender releases data during the ninth clock for the acknowledge.
// - Acknowledge accepted address, command and data bytes by pulling data low.
// - Write: address with direction zero, command; low six bits load the pointer.
// - Each data byte is acknowledged, stored at the pointer, then pointer advances.
// - Stop ends the transfer and returns the pointer to 00h.
// - Read: command, repeated Start, address with direction one, then register data.
// - Each master acknowledge advances the pointer and sends the next register.
// - Notify output low when an enabled fault log bit is set.
// - Event enable clears at reset; notify output starts released high.
// - Alert response address read: answer own address, then release notify.
// - Reading fault log or its clear-on-read copy releases notify.
// - No reassertion for a persisting fault; only new or recurring bits.
// - Several notifiers: lowest address wins arbitration and answers first.
// - Own address is 110 plus four bits from two three-state straps.
// - Also accept writes to the common broadcast write address.
// - Answer the alert response address only while notification is pending.
// - Pointer wraps from 31h to 00h when advancing.
module isai_top
#(
  parameter int STUCK_CYCLES = isai_pkg::STUCK_CYCLES
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_CLK_LINK,
  input wire logic I_SCL,
  input wire logic I_SERIAL_DATA_INPUT,
  input wire logic [1:0] I_ADDR_SEL1,
  input wire logic [1:0] I_ADDR_SEL0,
  input wire logic [7:0] I_FAULT_LOG,
  input wire logic [7:0] I_REG_RDATA,
  output logic O_SERIAL_DATA_OUTPUT_PULLDOWN,
  output logic O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N,
  output logic O_EVENT_NOTIFY_N,
  output logic [7:0] O_EVENT_ENABLE,
  output logic [5:0] O_REG_ADDR,
  output logic [7:0] O_REG_WDATA,
  output logic O_REG_WR_STB,
  output logic O_REG_RD_STB
);
  import isai_pkg::*;

  isai_xfer_if x();

  logic rst_l1, rst_l2;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic [1:0] sel1_s1, sel1_s2, sel0_s1, sel0_s2;
  logic pend_s1, pend_s2;
  logic stk_s1, stk_s2, stk_s3;
  logic stuck_tgl;
  logic [3:0] own_lo_reg;
  isai_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic oe_n_reg;
  logic sdo_reg;
  logic rd_dir_reg;
  logic ara_reg;
  logic [5:0] ptr_reg;
  logic req_reg;
  isai_op_t op_reg;
  logic [5:0] addr_reg;
  logic [7:0] wdata_reg;
  logic wr_stb_reg, rd_stb_reg, ara_stb_reg;
  logic [5:0] core_addr_reg;
  logic [7:0] core_wdata_reg;
  logic ack_reg;
  logic [7:0] ack_data_reg;
  logic [7:0] enable_reg;
  logic [7:0] seen_reg;
  logic notify_n_reg;
  logic link_rst_n, stuck_evt;
  logic scl_rise, scl_fall, start_det, stop_det, byte_end;
  logic own_hit, ara_hit, addr_hit, mack_ok;
  logic [6:0] own_addr;
  logic [7:0] tx_byte, armed, fresh;
  logic release_evt;

  isai_stuck_timer #(.CYCLES(STUCK_CYCLES)) u_timer
  (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_scl(I_SCL),
    .i_sda(I_SERIAL_DATA_INPUT),
    .o_expire_tgl(stuck_tgl)
  );

  isai_xfer_bridge u_bridge
  (
    .i_clk_sys(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_clk_link(I_CLK_LINK),
    .i_link_rst_n(link_rst_n),
    .x(x.bridge)
  );

  // Link domain synchronisers
  always_ff @(posedge I_CLK_LINK)
  begin
    rst_l1 <= I_RST_N;
    rst_l2 <= rst_l1;
    scl_s1 <= I_SCL;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= I_SERIAL_DATA_INPUT;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    sel1_s1 <= I_ADDR_SEL1;
    sel1_s2 <= sel1_s1;
    sel0_s1 <= I_ADDR_SEL0;
    sel0_s2 <= sel0_s1;
    pend_s1 <= ~notify_n_reg;
    pend_s2 <= pend_s1;
    stk_s1 <= stuck_tgl;
    stk_s2 <= stk_s1;
    stk_s3 <= stk_s2;
  end

  always_ff @(posedge I_CLK_LINK)
  begin
    if (!link_rst_n)
      own_lo_reg <= 4'hF;
    else
      own_lo_reg <= strap_low_bits(sel1_s2, sel0_s2);
  end

  assign link_rst_n = rst_l2;
  assign stuck_evt = stk_s2 ^ stk_s3;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_det = scl_s2 && scl_d && !sda_d && sda_s2;
  assign byte_end = scl_fall && (cnt_reg == BYTE_BITS);
  assign own_addr = {ADDR_FIXED_HI, own_lo_reg};
  assign own_hit = (sh_reg[7:1] == own_addr);
  assign ara_hit = (sh_reg[7:1] == ALERT_RESP_ADDR) && sh_reg[0] && pend_s2;
  assign addr_hit = own_hit || ara_hit || (sh_reg[7:1] == MASS_WRITE_ADDR && !sh_reg[0]);
  assign mack_ok = (state_reg == ST_MACK) && scl_rise && !sda_s2;
  assign tx_byte = ara_reg ? {own_addr, 1'b0} : x.rdata;

  // Byte engine: receive, acknowledge, transmit
  always_ff @(posedge I_CLK_LINK)
  begin
    if (!link_rst_n || stuck_evt)
    begin
      state_reg <= ST_IDLE;
      oe_n_reg <= 1'b1;
      sdo_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      rd_dir_reg <= 1'b0;
      ara_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= ST_ADDR;
      oe_n_reg <= 1'b1;
      cnt_reg <= 4'h0;
      ara_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg <= ST_IDLE;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_WDATA:
        begin
          if (scl_rise)
          begin
            sh_reg <= {sh_reg[6:0], sda_s2};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_reg <= 4'h0;
            if (state_reg == ST_ADDR)
            begin
              rd_dir_reg <= sh_reg[0];
              ara_reg <= ara_hit;
            end
            if (state_reg != ST_ADDR || addr_hit)
            begin
              oe_n_reg <= 1'b0;
              state_reg <= (state_reg == ST_ADDR) ? ST_ADDR_ACK :
                (state_reg == ST_CMD) ? ST_CMD_ACK : ST_WDATA_ACK;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall && rd_dir_reg)
          begin
            sh_reg <= tx_byte;
            oe_n_reg <= tx_byte[7];
            state_reg <= ST_TX;
          end
          else if (scl_fall)
          begin
            oe_n_reg <= 1'b1;
            state_reg <= ST_CMD;
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            oe_n_reg <= 1'b1;
            state_reg <= ST_WDATA;
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            cnt_reg <= cnt_reg + 4'h1;
            // Lost arbitration: a lower address is answering
            if (ara_reg && sh_reg[7] && !sda_s2)
            begin
              oe_n_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
          else if (byte_end)
          begin
            oe_n_reg <= 1'b1;
            cnt_reg <= 4'h0;
            state_reg <= ara_reg ? ST_IDLE : ST_MACK;
          end
          else if (scl_fall)
            oe_n_reg <= sh_reg[7];
        end
        ST_MACK:
        begin
          if (scl_rise)
            state_reg <= sda_s2 ? ST_IDLE : ST_RELOAD;
        end
        ST_RELOAD:
        begin
          if (scl_fall)
          begin
            sh_reg <= tx_byte;
            oe_n_reg <= tx_byte[7];
            state_reg <= ST_TX;
          end
        end
        default:
        begin
          oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Register pointer
  always_ff @(posedge I_CLK_LINK)
  begin
    if (!link_rst_n || stuck_evt || stop_det)
      ptr_reg <= PTR_RESET;
    else if (state_reg == ST_CMD && byte_end)
      ptr_reg <= sh_reg[5:0];
    else if ((state_reg == ST_WDATA_ACK && scl_fall) || mack_ok)
      ptr_reg <= ptr_advance(ptr_reg);
  end

  // Requests toward the register side
  always_ff @(posedge I_CLK_LINK)
  begin
    if (!link_rst_n || stuck_evt)
    begin
      req_reg <= 1'b0;
      op_reg <= OP_READ;
      addr_reg <= PTR_RESET;
      wdata_reg <= 8'h00;
    end
    else
    begin
      req_reg <= 1'b0;
      if (state_reg == ST_ADDR && byte_end && own_hit && sh_reg[0])
      begin
        req_reg <= 1'b1;
        op_reg <= OP_READ;
        addr_reg <= ptr_reg;
      end
      else if (mack_ok)
      begin
        req_reg <= 1'b1;
        op_reg <= OP_READ;
        addr_reg <= ptr_advance(ptr_reg);
      end
      else if (state_reg == ST_WDATA && byte_end)
      begin
        req_reg <= 1'b1;
        op_reg <= OP_WRITE;
        addr_reg <= ptr_reg;
        wdata_reg <= sh_reg;
      end
      else if (state_reg == ST_TX && byte_end && ara_reg)
      begin
        req_reg <= 1'b1;
        op_reg <= OP_ALERT_ANSWER;
      end
    end
  end

  assign x.req = req_reg;
  assign x.op = op_reg;
  assign x.addr = addr_reg;
  assign x.wdata = wdata_reg;

  // Register side strobes and answer
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      ara_stb_reg <= 1'b0;
      core_addr_reg <= PTR_RESET;
      core_wdata_reg <= 8'h00;
      ack_reg <= 1'b0;
      ack_data_reg <= 8'h00;
    end
    else
    begin
      wr_stb_reg <= x.stb && x.op == OP_WRITE;
      rd_stb_reg <= x.stb && x.op == OP_READ;
      ara_stb_reg <= x.stb && x.op == OP_ALERT_ANSWER;
      if (x.stb)
      begin
        core_addr_reg <= x.addr;
        core_wdata_reg <= x.wdata;
      end
      ack_reg <= wr_stb_reg || rd_stb_reg || ara_stb_reg;
      if (rd_stb_reg)
        ack_data_reg <= (core_addr_reg == REG_EVENT_ENABLE) ? enable_reg : I_REG_RDATA;
    end
  end

  assign x.ack = ack_reg;
  assign x.ack_data = ack_data_reg;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      enable_reg <= EVENT_ENABLE_RESET;
    else if (wr_stb_reg && core_addr_reg == REG_EVENT_ENABLE)
      enable_reg <= core_wdata_reg;
  end

  // Notification: only fault bits not yet reported raise it
  assign armed = I_FAULT_LOG & enable_reg;
  assign fresh = armed & ~seen_reg;
  assign release_evt = ara_stb_reg || (rd_stb_reg &&
    (core_addr_reg == REG_FAULT_LOG || core_addr_reg == REG_FAULT_LOG_COR));

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      seen_reg <= 8'h00;
    else
      seen_reg <= (seen_reg & I_FAULT_LOG) | armed;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      notify_n_reg <= 1'b1;
    else if (|fresh)
      notify_n_reg <= 1'b0;
    else if (release_evt)
      notify_n_reg <= 1'b1;
  end

  assign O_SERIAL_DATA_OUTPUT_PULLDOWN = sdo_reg;
  assign O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N = oe_n_reg;
  assign O_EVENT_NOTIFY_N = notify_n_reg;
  assign O_EVENT_ENABLE = enable_reg;
  assign O_REG_ADDR = core_addr_reg;
  assign O_REG_WDATA = core_wdata_reg;
  assign O_REG_WR_STB = wr_stb_reg;
  assign O_REG_RD_STB = rd_stb_reg;
endmodule
`default_nettype wire

// ### verilog/isai_pkg.sv
package isai_pkg;
  localparam logic [2:0] ADDR_FIXED_HI = 3'h6;
  localparam logic [6:0] MASS_WRITE_ADDR = 7'h66;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [5:0] PTR_LAST = 6'h31;
  localparam logic [5:0] REG_EVENT_ENABLE = 6'h01;
  localparam logic [5:0] REG_FAULT_LOG = 6'h03;
  localparam logic [5:0] REG_FAULT_LOG_COR = 6'h04;
  localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int STUCK_TIME_MS = 33;
  localparam int SYS_CLK_KHZ = 125000;
  localparam int STUCK_CYCLES = STUCK_TIME_MS * SYS_CLK_KHZ;
  // Three-state strap codes
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_OPEN = 2'h2;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ALERT_ANSWER} isai_op_t;
  typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WDATA,
    ST_WDATA_ACK, ST_TX, ST_MACK, ST_RELOAD} isai_state_t;

  function automatic logic [3:0] strap_low_bits(input logic [1:0] sel1, input logic [1:0] sel0);
    case ({sel1, sel0})
      {SEL_HIGH, SEL_LOW}: strap_low_bits = 4'h7;
      {SEL_OPEN, SEL_HIGH}: strap_low_bits = 4'h8;
      {SEL_HIGH, SEL_HIGH}: strap_low_bits = 4'h9;
      {SEL_OPEN, SEL_OPEN}: strap_low_bits = 4'hA;
      {SEL_OPEN, SEL_LOW}: strap_low_bits = 4'hB;
      {SEL_LOW, SEL_HIGH}: strap_low_bits = 4'hC;
      {SEL_HIGH, SEL_OPEN}: strap_low_bits = 4'hD;
      {SEL_LOW, SEL_OPEN}: strap_low_bits = 4'hE;
      default: strap_low_bits = 4'hF;
    endcase
  endfunction

  function automatic logic [5:0] ptr_advance(input logic [5:0] p);
    ptr_advance = (p == PTR_LAST) ? PTR_RESET : p + 6'h01;
  endfunction
endpackage

// ### verilog/isai_xfer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface isai_xfer_if;
  import isai_pkg::*;
  logic req;
  isai_op_t op;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  logic stb;
  logic ack;
  logic [7:0] ack_data;
  modport link (output req, op, addr, wdata, input done, rdata);
  modport bridge (input req, ack, ack_data, output done, rdata, stb);
  modport core (input stb, op, addr, wdata, output ack, ack_data);
endinterface
`default_nettype wire

// ### verilog/isai_xfer_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module isai_xfer_bridge
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  input wire logic i_link_rst_n,
  isai_xfer_if.bridge x
);
  import isai_pkg::*;

  logic req_tgl_reg;
  logic ack_s1, ack_s2, ack_s3;
  logic done_reg;
  logic [7:0] rdata_reg;
  logic req_s1, req_s2, req_s3;
  logic stb_reg;
  logic ack_tgl_reg;
  logic [7:0] data_sys_reg;

  // Link side: request toggle out, answer toggle in
  always_ff @(posedge i_clk_link)
  begin
    if (!i_link_rst_n)
    begin
      req_tgl_reg <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      req_tgl_reg <= req_tgl_reg ^ x.req;
      ack_s1 <= ack_tgl_reg;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      done_reg <= ack_s2 ^ ack_s3;
      if (ack_s2 ^ ack_s3)
        rdata_reg <= data_sys_reg;
    end
  end

  // System side: one strobe per request, answer held until the next
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      stb_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
      data_sys_reg <= 8'h00;
    end
    else
    begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      stb_reg <= req_s2 ^ req_s3;
      ack_tgl_reg <= ack_tgl_reg ^ x.ack;
      if (x.ack)
        data_sys_reg <= x.ack_data;
    end
  end

  assign x.done = done_reg;
  assign x.rdata = rdata_reg;
  assign x.stb = stb_reg;
endmodule
`default_nettype wire

// ### verilog/isai_stuck_timer.sv
`timescale 1ns/1ps
`default_nettype none
module isai_stuck_timer
#(
  parameter int CYCLES = isai_pkg::STUCK_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_expire_tgl
);
  import isai_pkg::*;

  localparam int W = $clog2(CYCLES + 2);
  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic [W-1:0] cnt_reg;
  logic expire_tgl_reg;

  always_ff @(posedge i_clk)
  begin
    scl_s1 <= i_scl;
    scl_s2 <= scl_s1;
    sda_s1 <= i_sda;
    sda_s2 <= sda_s1;
  end

  // Counts while either line is low, saturates one past the limit
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || (scl_s2 && sda_s2))
      cnt_reg <= '0;
    else if (cnt_reg <= LIMIT)
      cnt_reg <= cnt_reg + 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      expire_tgl_reg <= 1'b0;
    else if (!(scl_s2 && sda_s2) && cnt_reg == LIMIT)
      expire_tgl_reg <= ~expire_tgl_reg;
  end

  assign o_expire_tgl = expire_tgl_reg;
endmodule
`default_nettype wire

// ### dv/isai_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module isai_master_model
#(
  parameter int PHASE_NS = 800
)
(
  input wire logic i_bus_sda,
  output logic o_scl,
  output logic o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start or repeated Start, leaves the clock low
  task automatic start();
    o_sda = 1'b1;
    #(PHASE_NS);
    o_scl = 1'b1;
    #(PHASE_NS);
    o_sda = 1'b0;
    #(PHASE_NS);
    o_scl = 1'b0;
  endtask

  task automatic stop();
    #(PHASE_NS / 2);
    o_sda = 1'b0;
    #(PHASE_NS / 2);
    o_scl = 1'b1;
    #(PHASE_NS);
    o_sda = 1'b1;
    #(PHASE_NS);
  endtask

  // Data moves only while the clock is low
  task automatic put_bit(input logic b, output logic r);
    #(PHASE_NS / 2);
    o_sda = b;
    #(PHASE_NS / 2);
    o_scl = 1'b1;
    #(PHASE_NS / 2);
    r = i_bus_sda;
    #(PHASE_NS / 2);
    o_scl = 1'b0;
  endtask

  task automatic byte_wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic byte_rd(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      v[i] = r;
    end
    put_bit(~mack, r);
  endtask
endmodule
`default_nettype wire

// ### dv/isai_chk_props.sv
`timescale 1ns/1ps
`default_nettype none
module isai_chk_props
#(
  parameter int STUCK_CYCLES = 200
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SERIAL_DATA_INPUT,
  input wire logic [7:0] I_FAULT_LOG,
  input wire logic O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N,
  input wire logic O_EVENT_NOTIFY_N,
  input wire logic [7:0] O_EVENT_ENABLE,
  input wire logic [5:0] O_REG_ADDR,
  input wire logic [7:0] O_REG_WDATA,
  input wire logic O_REG_WR_STB,
  input wire logic O_REG_RD_STB
);
  import isai_pkg::*;
  int low_cnt;
  wire logic fe = |(I_FAULT_LOG & O_EVENT_ENABLE);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  // Cycles with either bus line low, saturating
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N || (I_SCL && I_SERIAL_DATA_INPUT))
      low_cnt <= 0;
    else if (low_cnt < STUCK_CYCLES + 40)
      low_cnt <= low_cnt + 1;
  end

  property p_reset_vals;
    disable iff (1'b0) !I_RST_N ##1 !I_RST_N |->
      O_EVENT_NOTIFY_N && O_EVENT_ENABLE == EVENT_ENABLE_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values");
  property p_oe_scl_low;
    $changed(O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N) |-> !I_SCL;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  property p_stuck;
    low_cnt == STUCK_CYCLES + 40 |-> O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N;
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck bus not released");
  property p_wr_pulse;
    O_REG_WR_STB |=> !O_REG_WR_STB;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_ptr_range;
    O_REG_WR_STB || O_REG_RD_STB |-> O_REG_ADDR <= PTR_LAST;
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer past last");
  property p_enable_wr;
    O_REG_WR_STB && O_REG_ADDR == REG_EVENT_ENABLE |=> O_EVENT_ENABLE == $past(O_REG_WDATA);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable not written");
  property p_notify_cause;
    $fell(O_EVENT_NOTIFY_N) |-> $past(fe);
  endproperty
  a_notify_cause: assert property (p_notify_cause) else $error("notify without fault");
  property p_notify_new;
    $rose(fe) |-> ##[1:2] !O_EVENT_NOTIFY_N;
  endproperty
  a_notify_new: assert property (p_notify_new) else $error("notify missing");
  property p_notify_read;
    O_REG_RD_STB && (O_REG_ADDR == REG_FAULT_LOG || O_REG_ADDR == REG_FAULT_LOG_COR)
      |-> ##[1:8] O_EVENT_NOTIFY_N;
  endproperty
  a_notify_read: assert property (p_notify_read) else $error("notify kept after read");
endmodule
`default_nettype wire

// ### dv/isai_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module isai_top_tb;
  import isai_pkg::*;
  localparam int STUCK = 5000;
  localparam logic [7:0] OWN_W = 8'hCE;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] fault = 8'h00;
  logic [1:0] sel1 = SEL_HIGH;
  logic [1:0] sel0 = SEL_LOW;
  logic m_scl, m_sda, bus_sda, oe_n, pd, notify_n, wr_stb, rd_stb, a, r;
  logic [7:0] enable, wdata, d;
  logic [5:0] raddr;
  logic [13:0] wq[$];
  int bad_count = 0;
  int compares = 0;

  always #4 clk_sys = ~clk_sys;
  initial
  begin
    #3.7;
    forever #16 clk_link = ~clk_link;
  end
  // Open-drain data line with pull-up
  assign bus_sda = m_sda & (oe_n | pd);

  isai_top #(.STUCK_CYCLES(STUCK)) isai_top_i (
    .I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .I_CLK_LINK(clk_link), .I_SCL(m_scl),
    .I_SERIAL_DATA_INPUT(bus_sda), .I_ADDR_SEL1(sel1), .I_ADDR_SEL0(sel0),
    .I_FAULT_LOG(fault), .I_REG_RDATA({2'h2, raddr}), .O_SERIAL_DATA_OUTPUT_PULLDOWN(pd),
    .O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N(oe_n), .O_EVENT_NOTIFY_N(notify_n),
    .O_EVENT_ENABLE(enable), .O_REG_ADDR(raddr), .O_REG_WDATA(wdata),
    .O_REG_WR_STB(wr_stb), .O_REG_RD_STB(rd_stb));
  isai_master_model isai_master_model_i (.i_bus_sda(bus_sda), .o_scl(m_scl), .o_sda(m_sda));

  always @(posedge clk_sys)
  begin
    if (wr_stb === 1'b1)
      wq.push_back({raddr, wdata});
  end

  task automatic end_of_test();
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_wr(input logic [5:0] ad, input logic [7:0] v);
    logic [13:0] w;
    w = 'x;
    if (wq.size() > 0)
      w = wq.pop_front();
    chk({2'h0, w}, {2'h0, ad, v});
  endtask
  task automatic m_start();
    isai_master_model_i.start();
  endtask
  task automatic m_stop();
    isai_master_model_i.stop();
  endtask
  task automatic tx(input logic [7:0] v, input logic exp_ack);
    isai_master_model_i.byte_wr(v, a);
    chk({15'h0, a}, {15'h0, exp_ack});
  endtask
  task automatic rx(input logic mack, input logic [7:0] exp_d);
    isai_master_model_i.byte_rd(mack, d);
    chk({8'h0, d}, {8'h0, exp_d});
  endtask
  task automatic rd_reg(input logic [5:0] p, input logic [7:0] exp_d);
    m_start();
    tx(OWN_W, 1'b1);
    tx({2'h0, p}, 1'b1);
    m_start();
    tx(8'hCF, 1'b1);
    rx(1'b0, exp_d);
    m_stop();
  endtask
  task automatic set_fault(input logic [7:0] v, input logic exp_n);
    @(posedge clk_sys);
    #1;
    fault = v;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({15'h0, notify_n}, {15'h0, exp_n});
  endtask

  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    chk({6'h0, pd, notify_n, enable}, {6'h0, 1'b0, 1'b1, EVENT_ENABLE_RESET});
    rst_n = 1'b1;
    #300;
    m_start();
    tx(OWN_W, 1'b1);
    tx(8'hF1, 1'b1);
    tx(8'hA5, 1'b1);
    tx(8'h5A, 1'b1);
    tx(8'h0F, 1'b1);
    m_stop();
    chk_wr(6'h31, 8'hA5);
    chk_wr(6'h00, 8'h5A);
    chk_wr(REG_EVENT_ENABLE, 8'h0F);
    m_start();
    tx(8'hCC, 1'b1);
    tx(8'h02, 1'b1);
    tx(8'h33, 1'b1);
    m_stop();
    chk_wr(6'h02, 8'h33);
    m_start();
    tx(8'hD0, 1'b0);
    m_stop();
    m_start();
    tx(OWN_W, 1'b1);
    tx(8'h30, 1'b1);
    m_start();
    tx(8'hCF, 1'b1);
    rx(1'b1, 8'hB0);
    rx(1'b1, 8'hB1);
    rx(1'b0, 8'h80);
    m_stop();
    m_start();
    tx(8'hCF, 1'b1);
    rx(1'b1, 8'h80);
    rx(1'b0, 8'h0F);
    m_stop();
    set_fault(8'h01, 1'b0);
    // A lower address wins the alert answer; this device backs off
    m_start();
    tx(8'h19, 1'b1);
    tx(8'hC0, 1'b0);
    m_stop();
    chk({15'h0, notify_n}, 16'h0000);
    m_start();
    tx(8'h19, 1'b1);
    rx(1'b0, OWN_W);
    m_stop();
    chk({15'h0, notify_n}, 16'h0001);
    set_fault(8'h01, 1'b1);
    m_start();
    tx(8'h19, 1'b0);
    m_stop();
    set_fault(8'h11, 1'b1);
    set_fault(8'h13, 1'b0);
    rd_reg(REG_FAULT_LOG, 8'h83);
    chk({15'h0, notify_n}, 16'h0001);
    set_fault(8'h00, 1'b1);
    set_fault(8'h01, 1'b0);
    rd_reg(REG_FAULT_LOG_COR, 8'h84);
    chk({15'h0, notify_n}, 16'h0001);
    m_start();
    for (int i = 7; i >= 0; i--)
      isai_master_model_i.put_bit(OWN_W[i], r);
    #400;
    chk({15'h0, oe_n}, 16'h0000);
    #50000;
    chk({15'h0, oe_n}, 16'h0001);
    tx(OWN_W, 1'b0);
    m_stop();
    m_start();
    tx(OWN_W, 1'b1);
    tx(8'h05, 1'b1);
    tx(8'h77, 1'b1);
    m_stop();
    chk_wr(6'h05, 8'h77);
    // Other strapping: open and high give address 68h
    sel1 = SEL_OPEN;
    sel0 = SEL_HIGH;
    m_start();
    tx(8'hD0, 1'b1);
    m_stop();
    end_of_test();
  end

  initial
  begin
    #800000;
    bad_count++;
    end_of_test();
  end
endmodule

bind isai_top isai_chk_props #(.STUCK_CYCLES(STUCK_CYCLES)) isai_chk_props_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_SCL(I_SCL),
  .I_SERIAL_DATA_INPUT(I_SERIAL_DATA_INPUT), .I_FAULT_LOG(I_FAULT_LOG),
  .O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N(O_SERIAL_DATA_OUTPUT_PULLDOWN_OE_N),
  .O_EVENT_NOTIFY_N(O_EVENT_NOTIFY_N), .O_EVENT_ENABLE(O_EVENT_ENABLE),
  .O_REG_ADDR(O_REG_ADDR), .O_REG_WDATA(O_REG_WDATA),
  .O_REG_WR_STB(O_REG_WR_STB), .O_REG_RD_STB(O_REG_RD_STB));
`default_nettype wire
